// [hw/rxq_regs.svh]
// Register map, field positions and constants of the receive qualifier block
`ifndef RXQ_REGS_SVH
`define RXQ_REGS_SVH
`define ADR_MODEM_CONFIG_TWO 8'h00
`define ADR_PACKET_CONTROL_ONE 8'h04
`define ADR_AGC_CONTROL_ZERO 8'h08
`define ADR_AGC_CONTROL_ONE 8'h0C
`define ADR_AGC_CONTROL_TWO 8'h10
`define ADR_RADIO_STATE_CONFIG_ONE 8'h14
`define ADR_PACKET_STATUS_REG 8'h18
`define ADR_SIGNAL_STRENGTH 8'h1C
`define ADR_LINK_QUALITY 8'h20
`define RST_MODEM_CONFIG_TWO 8'h02
`define RST_PACKET_CONTROL_ONE 8'h04
`define RST_AGC_CONTROL_ZERO 8'h01
`define RST_AGC_CONTROL_ONE 8'h00
`define RST_AGC_CONTROL_TWO 8'h03
`define RST_RADIO_STATE_CONFIG_ONE 8'h30
`define F_SYNC_MODE 2:0
`define F_PQT 7:5
`define F_APPEND 2
`define F_FILTER_LEN 1:0
`define F_REL_STEP 5:4
`define F_ABS_OFF 3:0
`define F_VGA_CEIL 7:6
`define F_LNA_CEIL 5:3
`define F_MAGN_GOAL 2:0
`define F_CCA_RULE 5:4
`define S_CS 6
`define S_PQ_MET 5
`define S_CCA 4
`define S_IN_PKT 3
`define PQ_MAX 5'h1F
`define PQ_DEC 5'h04
`define SYNC_ERR_15_16 6'h01
`define SYNC_ERR_30_32 6'h02
`define LQI_SYMBOLS 7'h40
`define CLK_KHZ 50000
`define RSSI_DIV 4
`endif

// [hw/rxq_pkg.sv]
// Types shared by the receive qualifier block
package rxq_pkg;
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_SEARCH = 2'b01,
    ST_PKT = 2'b11
  } rx_state_t;
  typedef enum logic [1:0] {
    CCA_ALWAYS = 2'h0,
    CCA_BELOW_THR = 2'h1,
    CCA_NOT_RX = 2'h2,
    CCA_BOTH = 2'h3
  } cca_rule_t;
  typedef struct packed {
    logic bit_valid;
    logic bit_val;
    logic sync_cand;
    logic [5:0] sync_err;
    logic sym_valid;
    logic [6:0] sym_quality;
    logic byte_valid;
    logic [7:0] byte_val;
    logic pkt_end;
    logic crc_ok;
  } demod_in_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic filter_en;
    logic app_valid;
    logic [7:0] app_rssi;
    logic [7:0] app_crc_lqi;
  } port_out_t;
endpackage : rxq_pkg

// [hw/rx_signal_qualifiers.sv]
// Receive signal qualifiers: sync gating, preamble quality, RSSI, CS, CCA, LINK_QUALITY_VALUE
// How it works
// R1 - Sync mode low bits pick none, 15/16, 16/16 or 30/32 sync bits.
// R2 - Sync mode top bit also demands carrier sense above threshold.
// R3 - With sync search on, no data or filtering before a qualified sync.
// R4 - Preamble quality counter rises by one on each bit change.
// R5 - It falls by four on repeated bits, saturating at 0 and 31.
// R6 - Sync allowed only while counter is at least four times threshold.
// R7 - Threshold zero removes the preamble quality condition.
// R8 - Status shows preamble quality met.
// R9 - Signal strength register, two's complement half dB, readable always.
// R10 - Strength updates every four channel bandwidth periods times two^filter length.
// R11 - Appending puts the last packet strength in the first status byte.
// R12 - Appending gives two bytes: strength, then CRC flag with link quality.
// R13 - Absolute carrier sense: above threshold sets, below with hysteresis clears.
// R14 - Relative carrier sense: step rise sets, equal step fall clears.
// R15 - Carrier sense as qualifier gates search; status shows the flag.
// R16 - Threshold is goal plus signed offset minus maximum gain.
// R17 - Maximum gain is cut by LNA and VGA ceiling fields.
// R18 - Software lowers the LNA ceiling before the VGA ceiling.
// R19 - Relative step selects off, 6, 10 or 14 dB.
// R20 - Status shows current clear channel state.
// R21 - Transmit strobes in receive succeed only on a clear channel.
// R22 - Clear channel rules: always, below threshold, not receiving, both.
// R23 - Rule codes 0 to 3 in that order.
// R24 - Link quality over 64 symbols after sync, readable and appended.
// R25 - Strength register is 8 bits and holds between updates.
//
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "rxq_regs.svh"
module rx_signal_qualifiers import rxq_pkg::*; #(
  parameter int CHAN_BW_KHZ = 200,
  parameter int RSSI_BASE_CYCLES = `CLK_KHZ * `RSSI_DIV / CHAN_BW_KHZ,
  parameter int GAIN_TOP_DB = 60,
  parameter int LNA_STEP_DB = 3,
  parameter int VGA_STEP_DB = 6,
  parameter int MAGN_BASE_DB = 24,
  parameter int MAGN_STEP_DB = 3,
  parameter int CS_HYST_HALF_DB = 2
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_active,
  input wire logic [7:0] level_sample,
  input wire demod_in_t demod,
  input wire logic transmit_strobe,
  input wire logic synth_tx_ready_strobe,
  output port_out_t radio_data_port,
  output logic tx_grant,
  output logic tx_refuse,
  output logic carrier_sense
);
  logic [1:0] rst_sync_q;
  logic rst_ok;
  logic [7:0] modem_config_two_q, packet_control_one_q, agc_control_zero_q;
  logic [7:0] agc_control_one_q, agc_control_two_q, radio_state_config_one_q;
  logic ack_q;
  logic [31:0] rdat_q;
  rx_state_t state_q;
  logic [4:0] pq_q;
  logic prev_bit_q;
  logic [7:0] rssi_q, rssi_prev_q;
  logic [15:0] upd_cnt_q;
  logic rssi_upd_q;
  logic abs_cs_q, rel_cs_q, cs_q;
  logic [6:0] lqi_q, lqi_sym_q;
  logic [12:0] lqi_acc_q;
  port_out_t port_q;
  logic grant_q, refuse_q;
  logic [2:0] sync_mode;
  logic [2:0] preamble_quality_threshold;
  logic pq_ok, bits_ok, sync_qual, gate_open, cca;
  logic [1:0] rel_step;
  logic signed [11:0] thr_half, rssi_x, prev_x, diff, step_half;
  logic [15:0] upd_period;
  logic [7:0] status_byte;

  function automatic logic signed [11:0] sx12(input logic [7:0] v);
    sx12 = {{4{v[7]}}, v};
  endfunction : sx12

  // Reset release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_ok = rst_sync_q[1];

  assign sync_mode = modem_config_two_q[`F_SYNC_MODE];
  assign preamble_quality_threshold = packet_control_one_q[`F_PQT];
  assign rel_step = agc_control_one_q[`F_REL_STEP];
  assign rssi_x = sx12(rssi_q);
  assign prev_x = sx12(rssi_prev_q);
  assign diff = rssi_x - prev_x;
  assign upd_period = 16'(RSSI_BASE_CYCLES << agc_control_zero_q[`F_FILTER_LEN]);

  // R16 threshold sum
  // R17 gain ceilings
  always_comb begin
    thr_half = 12'(2 * (MAGN_BASE_DB
      + MAGN_STEP_DB * int'(agc_control_two_q[`F_MAGN_GOAL])
      + int'($signed(agc_control_one_q[`F_ABS_OFF]))
      - (GAIN_TOP_DB - LNA_STEP_DB * int'(agc_control_two_q[`F_LNA_CEIL])
         - VGA_STEP_DB * int'(agc_control_two_q[`F_VGA_CEIL]))));
  end

  // R19 step select
  always_comb begin
    case (rel_step)
      2'h1: step_half = 12'sh00C;
      2'h2: step_half = 12'sh014;
      2'h3: step_half = 12'sh01C;
      default: step_half = 12'sh000;
    endcase
  end

  // R6 quality gate
  // R7 zero disables
  assign pq_ok = (preamble_quality_threshold == 3'h0) || ({2'h0, pq_q} >= {preamble_quality_threshold, 2'h0} + 7'h00);

  // R1 sync bit criteria
  always_comb begin
    case (sync_mode[1:0])
      2'h1: bits_ok = demod.sync_err <= `SYNC_ERR_15_16;
      2'h2: bits_ok = demod.sync_err == 6'h00;
      2'h3: bits_ok = demod.sync_err <= `SYNC_ERR_30_32;
      default: bits_ok = 1'b0;
    endcase
  end
  // R2 carrier sense qualifier
  // R15 search gated
  assign sync_qual = demod.sync_cand && bits_ok && pq_ok && (!sync_mode[2] || cs_q);

  // R3 data gate
  always_comb begin
    if (sync_mode[1:0] != 2'h0) begin
      gate_open = state_q == ST_PKT;
    end else begin
      gate_open = rx_active && (!sync_mode[2] || cs_q);
    end
  end

  // R22 clear channel rules
  // R23 rule coding
  always_comb begin
    case (cca_rule_t'(radio_state_config_one_q[`F_CCA_RULE]))
      CCA_BELOW_THR: cca = !cs_q;
      CCA_NOT_RX: cca = state_q != ST_PKT;
      CCA_BOTH: cca = !cs_q && state_q != ST_PKT;
      default: cca = 1'b1;
    endcase
  end

  // Receive state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_OFF;
    end else if (!rst_ok) begin
      state_q <= ST_OFF;
    end else begin
      case (state_q)
        ST_OFF: if (rx_active) state_q <= ST_SEARCH;
        ST_SEARCH: begin
          if (!rx_active) begin
            state_q <= ST_OFF;
          end else if (sync_qual) begin
            state_q <= ST_PKT;
          end
        end
        ST_PKT: begin
          if (!rx_active) begin
            state_q <= ST_OFF;
          end else if (demod.pkt_end) begin
            state_q <= ST_SEARCH;
          end
        end
        default: state_q <= ST_OFF;
      endcase
    end
  end

  // Preamble quality counter
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pq_q <= 5'h00;
      prev_bit_q <= 1'b0;
    end else if (demod.bit_valid) begin
      prev_bit_q <= demod.bit_val;
      if (demod.bit_val != prev_bit_q) begin
        // R4 count up
        if (pq_q != `PQ_MAX) pq_q <= pq_q + 5'h01;
      end else begin
        // R5 count down
        pq_q <= (pq_q > `PQ_DEC) ? pq_q - `PQ_DEC : 5'h00;
      end
    end
  end

  // R10 update timer
  // R25 hold between updates
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      upd_cnt_q <= 16'h0000;
      rssi_upd_q <= 1'b0;
      rssi_q <= 8'h80;
      rssi_prev_q <= 8'h80;
    end else begin
      rssi_upd_q <= 1'b0;
      if (!rx_active) begin
        upd_cnt_q <= 16'h0000;
      end else if (upd_cnt_q >= upd_period - 16'h0001) begin
        upd_cnt_q <= 16'h0000;
        rssi_upd_q <= 1'b1;
        // R9 strength sample
        rssi_q <= level_sample;
        rssi_prev_q <= rssi_q;
      end else begin
        upd_cnt_q <= upd_cnt_q + 16'h0001;
      end
    end
  end

  // Carrier sense
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      abs_cs_q <= 1'b0;
      rel_cs_q <= 1'b0;
      cs_q <= 1'b0;
    end else begin
      // R13 absolute hysteresis
      if (rssi_x > thr_half) begin
        abs_cs_q <= 1'b1;
      end else if (rssi_x < thr_half - 12'(CS_HYST_HALF_DB)) begin
        abs_cs_q <= 1'b0;
      end
      // R14 relative steps
      if (rel_step == 2'h0 || !rx_active) begin
        rel_cs_q <= 1'b0;
      end else if (rssi_upd_q && diff >= step_half) begin
        rel_cs_q <= 1'b1;
      end else if (rssi_upd_q && diff <= -step_half) begin
        rel_cs_q <= 1'b0;
      end
      cs_q <= rx_active && (abs_cs_q || rel_cs_q);
    end
  end

  // R24 link quality
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lqi_acc_q <= 13'h0000;
      lqi_sym_q <= 7'h00;
      lqi_q <= 7'h00;
    end else if (state_q != ST_PKT) begin
      lqi_acc_q <= 13'h0000;
      lqi_sym_q <= 7'h00;
    end else if (demod.sym_valid && lqi_sym_q < `LQI_SYMBOLS) begin
      lqi_sym_q <= lqi_sym_q + 7'h01;
      lqi_acc_q <= lqi_acc_q + {6'h00, demod.sym_quality};
      if (lqi_sym_q == `LQI_SYMBOLS - 7'h01) begin
        lqi_q <= 7'((lqi_acc_q + {6'h00, demod.sym_quality}) >> 6);
      end
    end
  end

  // Data port and status appending
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port_q <= '0;
    end else begin
      port_q.valid <= demod.byte_valid && gate_open;
      port_q.filter_en <= gate_open;
      if (demod.byte_valid) port_q.data <= demod.byte_val;
      // R11 strength byte
      // R12 two status bytes
      port_q.app_valid <= state_q == ST_PKT && demod.pkt_end
        && packet_control_one_q[`F_APPEND];
      if (state_q == ST_PKT && demod.pkt_end) begin
        port_q.app_rssi <= rssi_q;
        port_q.app_crc_lqi <= {demod.crc_ok, lqi_q};
      end
    end
  end

  // R21 transmit if clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      grant_q <= 1'b0;
      refuse_q <= 1'b0;
    end else begin
      grant_q <= (transmit_strobe || synth_tx_ready_strobe) && (!rx_active || cca);
      refuse_q <= (transmit_strobe || synth_tx_ready_strobe) && rx_active && !cca;
    end
  end

  // R8 quality met
  // R20 clear channel status
  assign status_byte = {1'b0, cs_q, pq_ok && preamble_quality_threshold != 3'h0, cca, state_q == ST_PKT, 3'h0};

  // Wishbone slave
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      modem_config_two_q <= `RST_MODEM_CONFIG_TWO;
      packet_control_one_q <= `RST_PACKET_CONTROL_ONE;
      agc_control_zero_q <= `RST_AGC_CONTROL_ZERO;
      agc_control_one_q <= `RST_AGC_CONTROL_ONE;
      agc_control_two_q <= `RST_AGC_CONTROL_TWO;
      radio_state_config_one_q <= `RST_RADIO_STATE_CONFIG_ONE;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q && rst_ok;
      if (wb_cyc_i && wb_stb_i && !ack_q && rst_ok) begin
        rdat_q <= 32'h0000_0000;
        if (wb_adr_i == `ADR_MODEM_CONFIG_TWO) begin
          rdat_q[7:0] <= modem_config_two_q;
          if (wb_we_i && wb_sel_i[0]) modem_config_two_q <= wb_dat_i[7:0];
        end else if (wb_adr_i == `ADR_PACKET_CONTROL_ONE) begin
          rdat_q[7:0] <= packet_control_one_q;
          if (wb_we_i && wb_sel_i[0]) packet_control_one_q <= wb_dat_i[7:0];
        end else if (wb_adr_i == `ADR_AGC_CONTROL_ZERO) begin
          rdat_q[7:0] <= agc_control_zero_q;
          if (wb_we_i && wb_sel_i[0]) agc_control_zero_q <= wb_dat_i[7:0];
        end else if (wb_adr_i == `ADR_AGC_CONTROL_ONE) begin
          rdat_q[7:0] <= agc_control_one_q;
          if (wb_we_i && wb_sel_i[0]) agc_control_one_q <= wb_dat_i[7:0];
        end else if (wb_adr_i == `ADR_AGC_CONTROL_TWO) begin
          rdat_q[7:0] <= agc_control_two_q;
          if (wb_we_i && wb_sel_i[0]) agc_control_two_q <= wb_dat_i[7:0];
        end else if (wb_adr_i == `ADR_RADIO_STATE_CONFIG_ONE) begin
          rdat_q[7:0] <= radio_state_config_one_q;
          if (wb_we_i && wb_sel_i[0]) radio_state_config_one_q <= wb_dat_i[7:0];
        end else if (wb_adr_i == `ADR_PACKET_STATUS_REG) begin
          rdat_q[7:0] <= status_byte;
        end else if (wb_adr_i == `ADR_SIGNAL_STRENGTH) begin
          rdat_q[7:0] <= rssi_q;
        end else if (wb_adr_i == `ADR_LINK_QUALITY) begin
          rdat_q[7:0] <= {1'b0, lqi_q};
        end
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign radio_data_port = port_q;
  assign tx_grant = grant_q;
  assign tx_refuse = refuse_q;
  assign carrier_sense = cs_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_ok);

  property p_pq_up;
    demod.bit_valid && demod.bit_val != prev_bit_q && pq_q != `PQ_MAX
      |=> pq_q == $past(pq_q) + 5'h01;
  endproperty
  a_pq_up: assert property (p_pq_up) else $error("quality count did not rise"); // R4
  property p_pq_down;
    demod.bit_valid && demod.bit_val == prev_bit_q
      |=> pq_q == (($past(pq_q) > 5'h04) ? $past(pq_q) - 5'h04 : 5'h00);
  endproperty
  a_pq_down: assert property (p_pq_down) else $error("quality count did not fall"); // R5
  property p_sync_gate;
    state_q == ST_SEARCH ##1 state_q == ST_PKT |-> $past(pq_ok);
  endproperty
  a_sync_gate: assert property (p_sync_gate) else $error("sync taken on poor preamble"); // R6
  property p_pqt_zero;
    state_q == ST_SEARCH && rx_active && preamble_quality_threshold == 3'h0 && demod.sync_cand && bits_ok
      && !sync_mode[2] |=> state_q == ST_PKT;
  endproperty
  a_pqt_zero: assert property (p_pqt_zero) else $error("zero threshold blocked sync"); // R7
  property p_mode16;
    state_q == ST_SEARCH && sync_mode[1:0] == 2'h2 ##1 state_q == ST_PKT
      |-> $past(demod.sync_err) == 6'h00;
  endproperty
  a_mode16: assert property (p_mode16) else $error("inexact sync accepted"); // R1
  property p_cs_qual;
    state_q == ST_SEARCH && sync_mode[2] ##1 state_q == ST_PKT |-> $past(cs_q);
  endproperty
  a_cs_qual: assert property (p_cs_qual) else $error("sync without carrier sense"); // R2
  property p_data_gate;
    sync_mode[1:0] != 2'h0 && state_q != ST_PKT |=> !port_q.valid;
  endproperty
  a_data_gate: assert property (p_data_gate) else $error("data before sync"); // R3
  property p_rssi_hold;
    !rssi_upd_q |-> $stable(rssi_q);
  endproperty
  a_rssi_hold: assert property (p_rssi_hold) else $error("strength changed off update"); // R25
  property p_tx_busy;
    (transmit_strobe || synth_tx_ready_strobe) && rx_active && !cca
      |=> tx_refuse && !tx_grant;
  endproperty
  a_tx_busy: assert property (p_tx_busy) else $error("busy channel not refused"); // R21
  property p_append;
    state_q == ST_PKT && demod.pkt_end && packet_control_one_q[`F_APPEND]
      |=> port_q.app_valid && port_q.app_rssi == $past(rssi_q);
  endproperty
  a_append: assert property (p_append) else $error("status bytes wrong"); // R11
  c_sync: cover property (state_q == ST_SEARCH ##1 state_q == ST_PKT);
  c_refuse: cover property (tx_refuse);
  c_append: cover property (port_q.app_valid);
endmodule : rx_signal_qualifiers
`default_nettype wire

// [dv/demod_model.sv]
// Demodulator datapath model: bit, sync, symbol, byte and packet end events
`timescale 1ns/1ps
`default_nettype none
module demod_model import rxq_pkg::*; (
  input wire logic clock,
  output demod_in_t demod
);
  initial demod = '0;
  // Bits one per cycle, toggling when t is set
  task automatic bits(input int n, input logic v, input logic t);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      demod.bit_valid <= 1'b1;
      demod.bit_val <= v;
      v = v ^ t;
    end
    @(posedge clock);
    demod.bit_valid <= 1'b0;
    demod.bit_val <= ~v;
  endtask : bits
  task automatic sync(input logic [5:0] e);
    @(posedge clock);
    demod.sync_cand <= 1'b1;
    demod.sync_err <= e;
    @(posedge clock);
    demod.sync_cand <= 1'b0;
    demod.sync_err <= ~e;
  endtask : sync
  task automatic byte_in(input logic [7:0] b);
    @(posedge clock);
    demod.byte_valid <= 1'b1;
    demod.byte_val <= b;
    @(posedge clock);
    demod.byte_valid <= 1'b0;
    demod.byte_val <= ~b;
  endtask : byte_in
  task automatic syms(input int n, input logic [6:0] s);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      demod.sym_valid <= 1'b1;
      demod.sym_quality <= s;
    end
    @(posedge clock);
    demod.sym_valid <= 1'b0;
    demod.sym_quality <= ~s;
  endtask : syms
  task automatic pkt_done(input logic c);
    @(posedge clock);
    demod.pkt_end <= 1'b1;
    demod.crc_ok <= c;
    @(posedge clock);
    demod.pkt_end <= 1'b0;
    demod.crc_ok <= ~c;
  endtask : pkt_done
endmodule : demod_model
`default_nettype wire

// [dv/test_rx_signal_qualifiers.sv]
// Self-checking bench of the receive qualifier block
`timescale 1ns/1ps
`default_nettype none
`include "rxq_regs.svh"
module test_rx_signal_qualifiers import rxq_pkg::*;;
  logic clock, rst_n, cyc, stb, we, ack, rx_active, tx_s, sy_s, grant, refuse, cs;
  logic [7:0] adr, level, q, vdat, arssi, acrc;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  demod_in_t demod;
  port_out_t port;
  int error_cnt, compares, vcnt, acnt, gcnt, rcnt, g0, r0;
  logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'h40};
  logic [7:0] rv [8] = '{8'h02, 8'h04, 8'h01, 8'h00, 8'h03, 8'h30, 8'h80, 8'h00};
  rx_signal_qualifiers #(.RSSI_BASE_CYCLES(8)) dut_u (.clock(clock), .rst_n(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rx_active(rx_active),
    .level_sample(level), .demod(demod), .transmit_strobe(tx_s),
    .synth_tx_ready_strobe(sy_s), .radio_data_port(port), .tx_grant(grant),
    .tx_refuse(refuse), .carrier_sense(cs));
  demod_model model_u (.clock(clock), .demod(demod));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Output event monitor
  always @(posedge clock) begin
    if (port.valid === 1'b1) begin
      vcnt++;
      vdat = port.data;
    end
    if (port.app_valid === 1'b1) begin
      acnt++;
      arssi = port.app_rssi;
      acrc = port.app_crc_lqi;
    end
    if (grant === 1'b1) gcnt++;
    if (refuse === 1'b1) rcnt++;
  end
  task automatic report_and_stop;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk("bus ack", 8'h01, {7'h00, ack});
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 8'h00);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic st(input logic [7:0] m, input logic [7:0] e);
    rd(`ADR_PACKET_STATUS_REG);
    chk("status", e, q & m);
  endtask : st
  task automatic lvl(input logic [7:0] v, input logic e);
    level <= v;
    repeat (30) @(posedge clock);
    chk("carrier sense", {7'h00, e}, {7'h00, cs});
    st(8'h40, {1'b0, e, 6'h00});
  endtask : lvl
  task automatic strobe(input logic s, input logic ok);
    g0 = gcnt;
    r0 = rcnt;
    @(posedge clock);
    if (s) sy_s <= 1'b1;
    else tx_s <= 1'b1;
    @(posedge clock);
    tx_s <= 1'b0;
    sy_s <= 1'b0;
    repeat (3) @(posedge clock);
    chk("grant", {7'h00, ok}, 8'(gcnt - g0));
    chk("refuse", {7'h00, !ok}, 8'(rcnt - r0));
  endtask : strobe
  initial begin
    repeat (30000) @(posedge clock);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    {rst_n, cyc, stb, we, rx_active, tx_s, sy_s} = 7'h00;
    {adr, level, sel, wdat} = {8'h00, 8'h80, 4'hF, 32'h00000000};
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      rd(ra[i]);
      chk("reset value", rv[i], q);
    end
    sel <= 4'h0;
    wr(`ADR_AGC_CONTROL_TWO, 8'hFF);
    sel <= 4'hF;
    rd(`ADR_AGC_CONTROL_TWO);
    chk("ignored write", 8'h03, q);
    wr(`ADR_AGC_CONTROL_ZERO, 8'h00);
    wr(`ADR_PACKET_CONTROL_ONE, 8'h24);
    wr(`ADR_MODEM_CONFIG_TWO, 8'h02);
    rx_active <= 1'b1;
    lvl(8'h10, 1'b1);
    rd(`ADR_SIGNAL_STRENGTH);
    chk("strength", 8'h10, q);
    model_u.bits(8, 1'b0, 1'b0);
    model_u.bits(3, 1'b1, 1'b1);
    st(8'h20, 8'h00);
    model_u.bits(1, 1'b0, 1'b0);
    st(8'h20, 8'h20);
    model_u.bits(1, 1'b0, 1'b0);
    st(8'h20, 8'h00);
    wr(`ADR_PACKET_CONTROL_ONE, 8'h44);
    model_u.bits(7, 1'b1, 1'b1);
    model_u.sync(6'h00);
    model_u.byte_in(8'h3C);
    st(8'h08, 8'h00);
    model_u.bits(1, 1'b0, 1'b0);
    model_u.sync(6'h01);
    st(8'h08, 8'h00);
    model_u.sync(6'h00);
    st(8'h08, 8'h08);
    model_u.byte_in(8'hA5);
    model_u.syms(64, 7'h28);
    chk("bytes out", 8'h01, 8'(vcnt));
    chk("byte data", 8'hA5, vdat);
    model_u.pkt_done(1'b1);
    repeat (2) @(posedge clock);
    chk("appends", 8'h01, 8'(acnt));
    chk("append strength", 8'h10, arssi);
    chk("append crc lqi", 8'hA8, acrc);
    rd(`ADR_LINK_QUALITY);
    chk("link quality", 8'h28, q);
    wr(`ADR_PACKET_CONTROL_ONE, 8'h04);
    wr(`ADR_MODEM_CONFIG_TWO, 8'h03);
    model_u.bits(2, 1'b0, 1'b0);
    model_u.sync(6'h03);
    st(8'h08, 8'h00);
    model_u.sync(6'h02);
    st(8'h08, 8'h08);
    model_u.pkt_done(1'b0);
    lvl(8'h80, 1'b0);
    wr(`ADR_MODEM_CONFIG_TWO, 8'h05);
    model_u.sync(6'h00);
    st(8'h08, 8'h00);
    lvl(8'h10, 1'b1);
    model_u.sync(6'h00);
    st(8'h08, 8'h08);
    model_u.pkt_done(1'b1);
    lvl(8'hC9, 1'b1);
    lvl(8'hC7, 1'b0);
    wr(`ADR_AGC_CONTROL_ONE, 8'h07);
    lvl(8'hD6, 1'b0);
    lvl(8'hDA, 1'b1);
    lvl(8'h88, 1'b0);
    wr(`ADR_AGC_CONTROL_TWO, 8'h0B);
    lvl(8'hDC, 1'b0);
    lvl(8'hE0, 1'b1);
    wr(`ADR_AGC_CONTROL_TWO, 8'h4B);
    lvl(8'hE8, 1'b0);
    lvl(8'hEC, 1'b1);
    wr(`ADR_AGC_CONTROL_TWO, 8'h03);
    lvl(8'h88, 1'b0);
    wr(`ADR_AGC_CONTROL_ONE, 8'h17);
    lvl(8'h9C, 1'b1);
    lvl(8'h88, 1'b0);
    lvl(8'hDA, 1'b1);
    for (int r = 0; r < 4; r++) begin
      wr(`ADR_RADIO_STATE_CONFIG_ONE, 8'(r << 4));
      st(8'h10, (r == 0 || r == 2) ? 8'h10 : 8'h00);
      strobe(r[0], r == 0 || r == 2);
    end
    rx_active <= 1'b0;
    strobe(1'b0, 1'b1);
    wr(`ADR_AGC_CONTROL_ZERO, 8'h02);
    level <= 8'h30;
    rx_active <= 1'b1;
    repeat (20) @(posedge clock);
    rd(`ADR_SIGNAL_STRENGTH);
    chk("strength held", 8'hDA, q);
    repeat (20) @(posedge clock);
    rd(`ADR_SIGNAL_STRENGTH);
    chk("strength updated", 8'h30, q);
    wr(`ADR_MODEM_CONFIG_TWO, 8'h00);
    model_u.byte_in(8'h5A);
    repeat (2) @(posedge clock);
    chk("bytes no sync", 8'h02, 8'(vcnt));
    chk("byte no sync", 8'h5A, vdat);
    report_and_stop();
  end
endmodule : test_rx_signal_qualifiers
`default_nettype wire
